// >>> drs_chk.sv
`timescale 1ns/100ps
`default_nettype none
`include "drs_regs.svh"

module drs_chk
(
  input wire logic                 aclk,
  input wire logic                 aresetn,
  input wire logic [7:0]           s_axi_awaddr,
  input wire logic                 s_axi_awvalid,
  input wire logic                 s_axi_awready,
  input wire logic [31:0]          s_axi_wdata,
  input wire logic [3:0]           s_axi_wstrb,
  input wire logic [7:0]           s_axi_araddr,
  input wire logic                 s_axi_arvalid,
  input wire logic [31:0]          s_axi_rdata,
  input wire logic                 s_axi_rvalid,
  input wire drs_pkg::drs_events_t dbg_events,
  input wire drs_pkg::drs_mode_t   dbg_mode,
  input wire logic                 debugger_on,
  input wire logic                 run_active_flag
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic       cw;
  logic       em;
  logic       wp_q;
  logic [7:0] ra_q;
  // Control write taken, end trace mode
  assign cw = s_axi_awvalid && s_axi_awready && s_axi_awaddr == `DRS_CTRL_OFS && s_axi_wstrb[0];
  assign em = !dbg_mode.trace_begin_sel && !dbg_mode.event_only_mode;
  // Write pending and last read address
  always_ff @(posedge aclk)
  begin
    wp_q <= aresetn && s_axi_awvalid && s_axi_awready;
    if (s_axi_arvalid)
      ra_q <= s_axi_araddr;
  end
  property p_start; cw && s_axi_wdata[7:6] == 2'b11 |=> ##1 run_active_flag && debugger_on; endproperty
  a_start: assert property (p_start) else $error("run not started");
  property p_stop; cw && s_axi_wdata[7:6] != 2'b11 |=> ##1 !run_active_flag; endproperty
  a_stop: assert property (p_stop) else $error("run not aborted");
  property p_off; cw && !s_axi_wdata[7] |=> ##1 !debugger_on; endproperty
  a_off: assert property (p_off) else $error("debugger still on");
  property p_on; run_active_flag |-> debugger_on; endproperty
  a_on: assert property (p_on) else $error("run while disabled");
  property p_trig; run_active_flag && em && dbg_events.trigger_event && !wp_q |=> !run_active_flag; endproperty
  a_trig: assert property (p_trig) else $error("end trace not ended");
  property p_full; run_active_flag && !em && dbg_events.fifo_full && !wp_q |=> !run_active_flag; endproperty
  a_full: assert property (p_full) else $error("begin trace not ended");
  property p_keep; run_active_flag && em && !dbg_events.trigger_event && !wp_q |=> run_active_flag; endproperty
  a_keep: assert property (p_keep) else $error("end trace ended early");
  property p_zero; s_axi_rvalid && ra_q == `DRS_STATUS_OFS |-> s_axi_rdata[4] == 1'b0 && s_axi_rdata[31:8] == 24'h0;
  endproperty
  a_zero: assert property (p_zero) else $error("status bit 4 set");
endmodule : drs_chk

bind drs_top drs_chk chk_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
  .s_axi_wstrb, .s_axi_araddr, .s_axi_arvalid, .s_axi_rdata, .s_axi_rvalid, .dbg_events, .dbg_mode,
  .debugger_on, .run_active_flag);

`default_nettype wire

// >>> drs_host_tally.sv
`timescale 1ns/100ps
`default_nettype none

module drs_host_tally
(
  input  wire logic       aclk,
  input  wire logic       load,
  input  wire logic [3:0] total,
  input  wire logic       take,
  output logic      [3:0] left_q
);
  // Host count of words still to read, seeded from the frozen count
  always_ff @(posedge aclk)
  begin
    if (load)
      left_q <= total;
    else if (take && left_q != 4'h0)
      left_q <= left_q - 4'h1;
  end
endmodule : drs_host_tally

`default_nettype wire

// >>> drs_pkg.sv
`default_nettype none

package drs_pkg;

  // Events from comparators, trigger logic and trace FIFO
  typedef struct packed {
    logic match_a;
    logic match_b;
    logic trigger_event;
    logic fifo_full;
    logic word_stored;
  } drs_events_t;

  // Trace mode as set by the trigger register
  typedef struct packed {
    logic trace_begin_sel;
    logic event_only_mode;
  } drs_mode_t;

  // Whole state of the block
  typedef struct packed {
    logic        debugger_on;
    logic        run_active_flag;
    logic        match_a_flag;
    logic        match_b_flag;
    logic [3:0]  fifo_valid_words;
    logic        aw_held;
    logic [7:0]  aw_addr;
    logic        w_held;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } drs_state_t;

endpackage : drs_pkg

`default_nettype wire

// >>> drs_regs.svh
`ifndef DRS_REGS_SVH
`define DRS_REGS_SVH

// ---------------------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------------------
`define DRS_CTRL_OFS      8'h00
`define DRS_STATUS_OFS    8'h04

// ---------------------------------------------------------------------------
// Control register fields
// ---------------------------------------------------------------------------
`define DRS_CTRL_ON_BIT   7
`define DRS_CTRL_RUN_BIT  6

// ---------------------------------------------------------------------------
// Status register fields and reset values
// ---------------------------------------------------------------------------
`define DRS_ST_A_BIT      7
`define DRS_ST_B_BIT      6
`define DRS_ST_RUN_BIT    5
`define DRS_ST_CNT_MSB    3
`define DRS_CNT_MAX       4'h8
`define DRS_CNT_RST       4'h0

// ---------------------------------------------------------------------------
// Bus responses
// ---------------------------------------------------------------------------
`define DRS_RESP_OKAY     2'b00
`define DRS_RESP_SLVERR   2'b10

`endif

// >>> drs_top.sv
// Functional notes
// - Status register is read-only; writes leave every status field unchanged.
// - Match A flag, bit 7, clears at run start, sets on A match during a run.
// - Match B flag, bit 6, clears at run start, sets on B match during a run.
// - Bit 5 mirrors the run-request bit while debugger_on is 1.
// - Run flag sets on writing run-request 1 together with debugger_on 1; clears at run end.
// - Begin run ends on FIFO full; end run ends on trigger event.
// - Writing 0 to run-request or debugger_on ends the run at once.
// - Count, bits 3:0, clears at start; holds valid words 0 to 8 at end.
// - Count never decrements when FIFO words are read out.
// - In event-only modes every run is treated as a begin trace.
//
// Chosen here: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
`include "drs_regs.svh"

module drs_top
(
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [7:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  input  wire drs_pkg::drs_events_t dbg_events,
  input  wire drs_pkg::drs_mode_t   dbg_mode,
  output logic                      debugger_on,
  output logic                      run_active_flag
);

  // -------------------------------------------------------------------------
  // State
  // -------------------------------------------------------------------------
  drs_pkg::drs_state_t s_q;
  drs_pkg::drs_state_t s_d;

  // -------------------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------------------

  // Word offset match within the register window
  function automatic logic addr_is(input logic [7:0] a, input logic [7:0] ofs);
    addr_is = (a[7:2] == ofs[7:2]);
  endfunction : addr_is

  // Status word image
  function automatic logic [7:0] status_image(input drs_pkg::drs_state_t s);
    logic [7:0] v;
    v                             = 8'h00;  // Bit 4 stays 0
    v[`DRS_ST_A_BIT]              = s.match_a_flag;
    v[`DRS_ST_B_BIT]              = s.match_b_flag;
    v[`DRS_ST_RUN_BIT]            = s.debugger_on & s.run_active_flag;
    v[`DRS_ST_CNT_MSB:0]          = s.fifo_valid_words;
    status_image                  = v;
  endfunction : status_image

  // Control word image
  function automatic logic [7:0] ctrl_image(input drs_pkg::drs_state_t s);
    logic [7:0] v;
    v                             = 8'h00;
    v[`DRS_CTRL_ON_BIT]           = s.debugger_on;
    v[`DRS_CTRL_RUN_BIT]          = s.run_active_flag;
    ctrl_image                    = v;
  endfunction : ctrl_image

  // -------------------------------------------------------------------------
  // Decoded strobes
  // -------------------------------------------------------------------------
  logic aw_take;
  logic w_take;
  logic ar_take;
  logic wr_fire;
  logic ctrl_wr;
  logic new_on;
  logic new_run;
  logic run_start;
  logic run_abort;
  logic begin_trace;
  logic run_done;

  // Channel readiness
  assign s_axi_awready = ~s_q.aw_held & ~s_q.bvalid;
  assign s_axi_wready  = ~s_q.w_held & ~s_q.bvalid;
  assign s_axi_arready = ~s_q.rvalid;
  assign aw_take       = s_axi_awvalid & s_axi_awready;
  assign w_take        = s_axi_wvalid & s_axi_wready;
  assign ar_take       = s_axi_arvalid & s_axi_arready;

  // Write fires once address and data are both held
  assign wr_fire   = s_q.aw_held & s_q.w_held & ~s_q.bvalid;
  assign ctrl_wr   = wr_fire & addr_is(s_q.aw_addr, `DRS_CTRL_OFS) & s_q.wstrb[0];
  assign new_on    = s_q.wdata[`DRS_CTRL_ON_BIT];
  assign new_run   = s_q.wdata[`DRS_CTRL_RUN_BIT];

  // Run start and manual abort
  assign run_start = ctrl_wr & new_on & new_run;
  assign run_abort = ctrl_wr & s_q.run_active_flag & ~(new_on & new_run);

  // Completion condition by trace type
  assign begin_trace = dbg_mode.trace_begin_sel | dbg_mode.event_only_mode;
  assign run_done    = s_q.run_active_flag &
                       (begin_trace ? dbg_events.fifo_full
                                    : dbg_events.trigger_event);

  // -------------------------------------------------------------------------
  // Next-state logic
  // -------------------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;

    // Capture write address and data in either order
    if (aw_take)
    begin
      s_d.aw_held = 1'b1;
      s_d.aw_addr = s_axi_awaddr;
    end
    if (w_take)
    begin
      s_d.w_held = 1'b1;
      s_d.wdata  = s_axi_wdata;
      s_d.wstrb  = s_axi_wstrb;
    end

    // Perform the write and raise the response
    if (wr_fire)
    begin
      s_d.aw_held = 1'b0;
      s_d.w_held  = 1'b0;
      s_d.bvalid  = 1'b1;
      if (addr_is(s_q.aw_addr, `DRS_CTRL_OFS) ||
          addr_is(s_q.aw_addr, `DRS_STATUS_OFS))
      begin
        s_d.bresp = `DRS_RESP_OKAY;  // Status write accepted, no effect
      end
      else
      begin
        s_d.bresp = `DRS_RESP_SLVERR;
      end
    end
    if (s_q.bvalid && s_axi_bready)
    begin
      s_d.bvalid = 1'b0;
    end

    // Control register update
    if (ctrl_wr)
    begin
      s_d.debugger_on = new_on;
    end

    // Run flag: completion or abort clears it, a start sets it
    if (run_done || run_abort)
    begin
      s_d.run_active_flag = 1'b0;
    end
    if (run_start)
    begin
      s_d.run_active_flag = 1'b1;
    end

    // Match flags clear at start, set on a match while armed
    if (run_start)
    begin
      s_d.match_a_flag = 1'b0;
      s_d.match_b_flag = 1'b0;
    end
    if (s_q.run_active_flag && dbg_events.match_a)
    begin
      s_d.match_a_flag = 1'b1;  // Set wins over clear
    end
    if (s_q.run_active_flag && dbg_events.match_b)
    begin
      s_d.match_b_flag = 1'b1;  // Set wins over clear
    end

    // Valid-word count: counts stores during a run, frozen after
    if (run_start)
    begin
      s_d.fifo_valid_words = `DRS_CNT_RST;
    end
    else if (s_q.run_active_flag && dbg_events.word_stored &&
             s_q.fifo_valid_words != `DRS_CNT_MAX)
    begin
      s_d.fifo_valid_words = s_q.fifo_valid_words + 4'h1;  // Never decrements
    end

    // Read channel
    if (ar_take)
    begin
      s_d.rvalid = 1'b1;
      s_d.rresp  = `DRS_RESP_OKAY;
      s_d.rdata  = 32'h0000_0000;
      if (addr_is(s_axi_araddr, `DRS_STATUS_OFS))
      begin
        s_d.rdata[7:0] = status_image(s_q);
      end
      else if (addr_is(s_axi_araddr, `DRS_CTRL_OFS))
      begin
        s_d.rdata[7:0] = ctrl_image(s_q);
      end
      else
      begin
        s_d.rresp = `DRS_RESP_SLVERR;
      end
    end
    else if (s_q.rvalid && s_axi_rready)
    begin
      s_d.rvalid = 1'b0;
    end
  end

  // -------------------------------------------------------------------------
  // State register
  // -------------------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // -------------------------------------------------------------------------
  // Outputs
  // -------------------------------------------------------------------------
  assign s_axi_bvalid    = s_q.bvalid;
  assign s_axi_bresp     = s_q.bresp;
  assign s_axi_rvalid    = s_q.rvalid;
  assign s_axi_rdata     = s_q.rdata;
  assign s_axi_rresp     = s_q.rresp;
  assign debugger_on     = s_q.debugger_on;
  assign run_active_flag = s_q.run_active_flag;

endmodule : drs_top

`default_nettype wire

// >>> tb_debug_run_status.sv
`timescale 1ns/100ps
`default_nettype none

module tb_debug_run_status;
  logic                 aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, tload, ttake;
  logic                 s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic                 debugger_on, run_active_flag;
  logic [7:0]           s_axi_awaddr, s_axi_araddr;
  logic [31:0]          s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]           s_axi_wstrb, left;
  logic [1:0]           s_axi_bresp, s_axi_rresp;
  drs_pkg::drs_events_t dbg_events;
  drs_pkg::drs_mode_t   dbg_mode;
  int                   n_mismatch, total_checks;

  drs_top dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .dbg_events, .dbg_mode,
    .debugger_on, .run_active_flag);
  drs_host_tally tally_u (.aclk, .load(tload), .total(rd[3:0]), .take(ttake), .left_q(left));

  // Clock
  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : complete_run

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      n++;
    end while (s_axi_bvalid !== 1'b1 && n < 50);
    if (s_axi_bvalid !== 1'b1) n_mismatch++;
    if (s_axi_bvalid !== 1'b1) complete_run();
    chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      n++;
    end while (s_axi_rvalid !== 1'b1 && n < 50);
    if (s_axi_rvalid !== 1'b1) n_mismatch++;
    if (s_axi_rvalid !== 1'b1) complete_run();
    rd = s_axi_rdata;
    chk("rdata", e, rd);
    chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
    s_axi_rready <= 1'b0;
  endtask : rdc

  task automatic pulse(input drs_pkg::drs_events_t e);
    @(posedge aclk);
    dbg_events <= e;
    @(posedge aclk);
    dbg_events <= '0;
  endtask : pulse

  // Main sequence
  initial
  begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, tload, ttake} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, rd} = '0;
    s_axi_wstrb = 4'hf;
    dbg_events = '0;
    dbg_mode = 2'b10;
    n_mismatch = 0;
    total_checks = 0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rdc(8'h04, 32'h00, 2'b00);
    rdc(8'h08, 32'h00, 2'b10);
    wr(8'h0c, 32'h00, 2'b10);
    wr(8'h00, 32'hc0, 2'b00);
    rdc(8'h04, 32'h20, 2'b00);
    pulse(5'h19);
    pulse(5'h01);
    pulse(5'h01);
    rdc(8'h04, 32'he3, 2'b00);
    wr(8'h04, 32'hff, 2'b00);
    rdc(8'h04, 32'he3, 2'b00);
    repeat (6) pulse(5'h01);
    rdc(8'h04, 32'he8, 2'b00);
    pulse(5'h02);
    rdc(8'h04, 32'hc8, 2'b00);
    tload <= 1'b1;
    @(posedge aclk);
    tload <= 1'b0;
    ttake <= 1'b1;
    repeat (5) @(posedge aclk);
    ttake <= 1'b0;
    @(posedge aclk);
    chk("tally", 32'h3, {28'h0, left});
    pulse(5'h01);
    rdc(8'h04, 32'hc8, 2'b00);
    dbg_mode <= 2'b00;
    wr(8'h00, 32'hc0, 2'b00);
    pulse(5'h02);
    rdc(8'h04, 32'h20, 2'b00);
    pulse(5'h04);
    pulse(5'h19);
    rdc(8'h04, 32'h00, 2'b00);
    dbg_mode <= 2'b01;
    wr(8'h00, 32'hc0, 2'b00);
    pulse(5'h02);
    rdc(8'h04, 32'h00, 2'b00);
    wr(8'h00, 32'hc0, 2'b00);
    wr(8'h00, 32'h80, 2'b00);
    chk("run", 32'h0, {31'h0, run_active_flag});
    wr(8'h00, 32'hc0, 2'b00);
    wr(8'h00, 32'h40, 2'b00);
    chk("on", 32'h0, {31'h0, debugger_on});
    chk("run", 32'h0, {31'h0, run_active_flag});
    s_axi_wstrb <= 4'he;
    wr(8'h00, 32'hc0, 2'b00);
    chk("on", 32'h0, {31'h0, debugger_on});
    complete_run();
  end
endmodule : tb_debug_run_status

`default_nettype wire
